/* src/lbcl_device.sv */
// Operation
// - Read autoprecharge bank idles after precharge time
// - Write autoprecharge bank idles after precharge time
// - Controller sends only NOP in device-wide states
// - Refresh holds device until refresh time met
// - Mode load holds device until delay met
// - Precharge all idles every bank after precharge
// - Unlisted state and command pairs are illegal
// - Refresh and mode load need all idle
// - Multi-bank precharge needs each bank prechargeable
// - Burst terminate hits most recent read burst without autoprecharge
// - Auto and plain precharge variants both allowed
// - Write during read without autoprecharge needs completion or terminate
// - Commands decode from four command pins
// - Idle bank leaves other banks unconstrained
// - Checking only with clock enable high twice
// - Bank states follow precharge, activate, bursts
// - Read autoprecharge splits access then precharge
// - Write autoprecharge precharge begins after recovery
// - Concurrent autoprecharge accepts other-bank commands
// - Write autoprecharge delays to other banks
// - Precharge holds bank until precharge time met
// - Activate holds bank until activate delay met
module lbcl_device
  import lbcl_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Command bus
  lbcl_cmd_if.device cmd,
  // Status
  output logic o_all_idle,
  output logic [4*lbcl_pkg::NUM_BANKS-1:0] o_bank_state,
  output logic [1:0] o_dev_state,
  output logic o_illegal
);
  import lbcl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic cke_prev;
  wire checking = cke_prev & cmd.cke;
  wire [3:0] pins = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
  wire is_desel = cmd.cs_n;
  wire is_exec = checking & ~is_desel & (pins != CMD_NOP);
  wire is_act = is_exec & (pins == CMD_ACTIVE);
  wire is_rd = is_exec & (pins == CMD_READ);
  wire is_wr = is_exec & (pins == CMD_WRITE);
  wire is_pre = is_exec & (pins == CMD_PRECHARGE);
  wire is_ref = is_exec & (pins == CMD_REFRESH);
  wire is_lmr = is_exec & (pins == CMD_LOAD_MODE);
  wire is_bst = is_exec & (pins == CMD_BURST_STOP);

  lbcl_dev_type dev, next_dev;
  logic [CNT_W-1:0] dev_cnt, next_dev_cnt;
  lbcl_bank_type st [NUM_BANKS];
  logic [CNT_W-1:0] cnt [NUM_BANKS];
  logic [CNT_W-1:0] wra_gap;
  logic [BANK_W-1:0] last_rd_bank;
  logic last_rd_live;

  logic [NUM_BANKS-1:0] idle_v, pre_ok_v, sel_v;
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      idle_v[i] = (st[i] == BANK_IDLE);
      // A bank already precharging is not interrupted
      pre_ok_v[i] = (st[i] != BANK_ACTIVATING) & (st[i] != BANK_READ_AP)
        & (st[i] != BANK_WRITE_AP) & (st[i] != BANK_PRECHARGING);
      sel_v[i] = cmd.a10 | (cmd.bank == BANK_W'(i));
    end
  end
  wire all_idle = &idle_v;
  lbcl_bank_type tgt;
  assign tgt = st[cmd.bank];
  wire any_rd = (st[0] == BANK_READ) | (st[1] == BANK_READ)
    | (st[2] == BANK_READ) | (st[3] == BANK_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Legality check
  // both variants
  wire col_ok = (tgt == BANK_ROW_ACTIVE) | (tgt == BANK_READ)
    | (tgt == BANK_WRITE);
  wire wr_block = any_rd;
  wire rd_gap_bad = (wra_gap < CNT_W'(WRA_TO_RD_CYC));
  wire wr_gap_bad = (wra_gap < CNT_W'(WRA_TO_WR_CYC));
  wire oth_gap_bad = (wra_gap < CNT_W'(WRA_TO_OTHER_CYC));
  wire pre_ok = &(pre_ok_v | ~sel_v);
  wire dev_busy = (dev != DEV_NORMAL);
  // refresh and load need all idle
  // activate, read, write and precharge see their bank's state and the wra_gap delays; write also any_rd; burst stop needs last_rd_live
  wire bad = is_exec & (dev_busy
    | (is_act & ((tgt != BANK_IDLE) | oth_gap_bad))
    | (is_rd & (~col_ok | rd_gap_bad))
    | (is_wr & (~col_ok | wr_block | wr_gap_bad))
    | (is_pre & (~pre_ok | oth_gap_bad))
    | ((is_ref | is_lmr) & ~all_idle)
    | (is_bst & ~last_rd_live));
  wire ok = is_exec & ~bad;

  ////////////////////////////////////////////////////////////////////////////
  // Device-wide state
  // device-level tracker
  always_comb begin
    next_dev = dev;
    next_dev_cnt = (dev_cnt != '0) ? dev_cnt - CNT_W'(1) : dev_cnt;
    case (dev)
      DEV_NORMAL: begin
        if (ok & is_ref) begin
          next_dev = DEV_REFRESHING;
          next_dev_cnt = CNT_W'(RFC_CYC - 1);
        end else if (ok & is_lmr) begin
          next_dev = DEV_MODE_ACCESS;
          next_dev_cnt = CNT_W'(MRD_CYC - 1);
        end else if (ok & is_pre & cmd.a10) begin
          next_dev = DEV_PRECHARGE_ALL;
          next_dev_cnt = CNT_W'(RP_CYC - 1);
        end
      end
      default: begin
        if (dev_cnt == '0) begin
          next_dev = DEV_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dev <= DEV_NORMAL;
      dev_cnt <= '0;
      cke_prev <= 1'b0;
      o_illegal <= 1'b0;
      wra_gap <= '1;
    end else begin
      dev <= next_dev;
      dev_cnt <= next_dev_cnt;
      cke_prev <= cmd.cke;
      o_illegal <= bad;
      if (ok & is_wr & cmd.a10) begin
        wra_gap <= CNT_W'(1);
      end else if (wra_gap != '1) begin
        wra_gap <= wra_gap + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst terminate target
  // most recent read without autoprecharge
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_rd_bank <= '0;
      last_rd_live <= 1'b0;
    end else if (ok & is_rd & ~cmd.a10) begin
      last_rd_bank <= cmd.bank;
      last_rd_live <= 1'b1;
    end else if ((ok & (is_bst | is_rd | is_wr))
        | (st[last_rd_bank] != BANK_READ)) begin
      last_rd_live <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank trackers
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    lbcl_bank_type next_st;
    logic [CNT_W-1:0] next_cnt;
    wire hit = (cmd.bank == BANK_W'(b));
    wire done = (cnt[b] == '0);
    always_comb begin
      next_st = st[b];
      next_cnt = done ? cnt[b] : cnt[b] - CNT_W'(1);
      if (dev == DEV_PRECHARGE_ALL) begin
        next_st = (dev_cnt == '0) ? BANK_IDLE : BANK_PRECHARGING;
      end else if (ok & is_pre & sel_v[b] & st[b] != BANK_IDLE) begin
        next_st = BANK_PRECHARGING;
        next_cnt = CNT_W'(RP_CYC - 1);
      end else if (ok & is_act & hit) begin
        next_st = BANK_ACTIVATING;
        next_cnt = CNT_W'(RCD_CYC - 1);
      end else if (ok & is_rd & hit) begin
        next_st = cmd.a10 ? BANK_READ_AP : BANK_READ;
        next_cnt = cmd.a10 ? CNT_W'(BURST_CYC + RP_CYC - 1)
          : CNT_W'(RD_END_CYC - 1);
      end else if (ok & is_wr & hit) begin
        next_st = cmd.a10 ? BANK_WRITE_AP : BANK_WRITE;
        next_cnt = cmd.a10 ? CNT_W'(WR_END_CYC + WR_CYC + RP_CYC - 1)
          : CNT_W'(WR_END_CYC - 1);
      end else if (ok & is_bst & (last_rd_bank == BANK_W'(b))) begin
        next_st = BANK_ROW_ACTIVE;
      end else if (done) begin
        case (st[b])
          BANK_ACTIVATING: next_st = BANK_ROW_ACTIVE;
          BANK_READ: next_st = BANK_ROW_ACTIVE;
          BANK_WRITE: next_st = BANK_ROW_ACTIVE;
          BANK_READ_AP: next_st = BANK_IDLE;
          BANK_WRITE_AP: next_st = BANK_IDLE;
          BANK_PRECHARGING: next_st = BANK_IDLE;
          default: next_st = st[b];
        endcase
      end
    end
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        st[b] <= BANK_IDLE;
        cnt[b] <= '0;
      end else begin
        st[b] <= next_st;
        cnt[b] <= next_cnt;
      end
    end
    assign o_bank_state[4*b +: 4] = st[b];
  end

  assign o_all_idle = all_idle & (dev == DEV_NORMAL);
  assign o_dev_state = dev;
  assign cmd.illegal = o_illegal;

endmodule // lbcl_device

/* shared/lbcl_pkg.sv */
package lbcl_pkg;

  // Bank count and bank address width
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;

  // Command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;

  // Clock and timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_RP_PS = 15000;
  localparam int T_RCD_PS = 15000;
  localparam int T_RFC_PS = 72000;
  localparam int T_MRD_PS = 10000;
  localparam int T_WR_PS = 15000;
  localparam int T_WTR_CK = 1;
  localparam int CAS_LAT = 3;
  localparam int BURST_LEN = 4;
  localparam int CNT_W = 8;

  // Least times round up to whole cycles
  localparam int RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RCD_CYC = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MRD_CYC = (T_MRD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_CYC = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BURST_CYC = BURST_LEN / 2;
  localparam int RD_END_CYC = CAS_LAT + BURST_CYC;
  localparam int WR_END_CYC = 1 + BURST_CYC;
  // Delays after a write with auto precharge to another bank
  localparam int WRA_TO_RD_CYC = 1 + BURST_CYC + T_WTR_CK;
  localparam int WRA_TO_WR_CYC = BURST_CYC;
  localparam int WRA_TO_OTHER_CYC = 1;

  // Per-bank states
  typedef enum logic [3:0] {
    BANK_IDLE = 4'h0,
    BANK_ACTIVATING = 4'h1,
    BANK_ROW_ACTIVE = 4'h2,
    BANK_READ = 4'h3,
    BANK_WRITE = 4'h4,
    BANK_READ_AP = 4'h5,
    BANK_WRITE_AP = 4'h6,
    BANK_PRECHARGING = 4'h7
  } lbcl_bank_type;

  // Device-wide states
  typedef enum logic [1:0] {
    DEV_NORMAL = 2'h0,
    DEV_REFRESHING = 2'h1,
    DEV_MODE_ACCESS = 2'h2,
    DEV_PRECHARGE_ALL = 2'h3
  } lbcl_dev_type;

endpackage

/* shared/lbcl_cmd_if.sv */
interface lbcl_cmd_if;
  import lbcl_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BANK_W-1:0] bank;
  logic a10;
  logic illegal;

  modport controller (
    output cke, cs_n, ras_n, cas_n, we_n, bank, a10,
    input illegal
  );
  modport device (
    input cke, cs_n, ras_n, cas_n, we_n, bank, a10,
    output illegal
  );
endinterface

/* src/lbcl_controller.sv */
module lbcl_controller
  import lbcl_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // User request
  input wire logic i_req_valid,
  input wire logic [3:0] i_req_cmd,
  input wire logic [lbcl_pkg::BANK_W-1:0] i_req_bank,
  input wire logic i_req_a10,
  input wire logic i_cke,
  output logic o_req_ready,
  output logic o_illegal_seen,
  // Command bus
  lbcl_cmd_if.controller cmd
);
  import lbcl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Hold-off for device-wide states
  logic [CNT_W-1:0] hold;
  logic [3:0] pins;
  logic [BANK_W-1:0] bank_q;
  logic a10_q;
  // only NOP while device is busy
  wire busy = (hold != '0);
  wire take = i_req_valid & ~busy;
  wire [CNT_W-1:0] hold_len =
    (i_req_cmd == CMD_REFRESH) ? CNT_W'(RFC_CYC) :
    (i_req_cmd == CMD_LOAD_MODE) ? CNT_W'(MRD_CYC) :
    ((i_req_cmd == CMD_PRECHARGE) & i_req_a10) ? CNT_W'(RP_CYC) : '0;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold <= '0;
      pins <= CMD_NOP;
      bank_q <= '0;
      a10_q <= 1'b0;
      o_illegal_seen <= 1'b0;
    end else begin
      pins <= take ? i_req_cmd : CMD_NOP;
      bank_q <= take ? i_req_bank : bank_q;
      a10_q <= take ? i_req_a10 : a10_q;
      hold <= take ? hold_len : (busy ? hold - CNT_W'(1) : hold);
      o_illegal_seen <= o_illegal_seen | cmd.illegal;
    end
  end

  assign o_req_ready = ~busy;
  assign cmd.cke = i_cke;
  assign cmd.cs_n = pins[3];
  assign cmd.ras_n = pins[2];
  assign cmd.cas_n = pins[1];
  assign cmd.we_n = pins[0];
  assign cmd.bank = bank_q;
  assign cmd.a10 = a10_q;

endmodule // lbcl_controller

/* verification/lbcl_cmd_props.sv */
module lbcl_cmd_props
  import lbcl_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Command bus
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank,
  input wire logic a10,
  input wire logic illegal
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  wire logic [3:0] code;
  wire logic quiet;
  wire logic live;
  logic cke_q;
  logic [3:0] since_rd;
  assign code = {cs_n, ras_n, cas_n, we_n};
  assign quiet = cs_n || code == CMD_NOP;
  assign live = cke && cke_q;

  // Cycles since the last read, saturating
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cke_q <= 1'b0;
      since_rd <= 4'hf;
    end else begin
      cke_q <= cke;
      since_rd <= (code == CMD_READ) ? 4'h0
        : since_rd + {3'h0, since_rd != 4'hf};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  illegal_cause_a:
    assert property (illegal |-> !$past(quiet))
    else $error("flag without an executable command");
  refresh_quiet_a:
    assert property (live && code == CMD_REFRESH |=> quiet[*8])
    else $error("command during refresh");
  mode_quiet_a:
    assert property (live && code == CMD_LOAD_MODE |=> quiet)
    else $error("command during mode access");
  prea_quiet_a:
    assert property (live && code == CMD_PRECHARGE && a10 |=> quiet)
    else $error("command during precharge all");
  cke_gate_a:
    assert property (!live && !quiet |=> !illegal)
    else $error("checked with clock enable low");
  wr_after_rd_a:
    assert property (live && code == CMD_READ && !a10 ##1 !illegal
      ##1 live && code == CMD_WRITE |=> illegal)
    else $error("write during read not flagged");
  act_twice_a:
    assert property (live && code == CMD_ACTIVE ##1 !illegal
      ##1 live && code == CMD_ACTIVE && bank == $past(bank, 2) |=> illegal)
    else $error("activate of busy bank not flagged");
  bst_orphan_a:
    assert property (live && code == CMD_BURST_STOP && since_rd > 4'h8
      |=> illegal)
    else $error("orphan terminate not flagged");
  refresh_busy_a:
    assert property (live && code == CMD_ACTIVE ##1 !illegal
      ##1 live && code == CMD_REFRESH |=> illegal)
    else $error("refresh with busy bank not flagged");
  pre_busy_a:
    assert property (live && code == CMD_ACTIVE ##1 !illegal
      ##1 live && code == CMD_PRECHARGE && (a10 || bank == $past(bank, 2))
      |=> illegal)
    else $error("precharge of activating bank not flagged");
  wra_read_gap_a:
    assert property (live && code == CMD_WRITE && a10 ##1 !illegal
      ##1 live && code == CMD_READ |=> illegal)
    else $error("read too soon after write autoprecharge");

  cover property (live && code == CMD_REFRESH);
  cover property (live && code == CMD_WRITE && a10);
  cover property (illegal);
endmodule // lbcl_cmd_props

/* verification/tb.sv */
module tb
  import lbcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [3:0] req_cmd = CMD_NOP;
  logic [1:0] req_bank = 2'h0;
  logic req_a10 = 1'b0;
  logic cke = 1'b1;
  logic req_ready, illegal_seen, all_idle;
  logic [15:0] bank_state;
  logic [1:0] dev_state;
  int mismatches = 0;
  int check_count = 0;
  logic [3:0] bad_cmd [8] = '{CMD_READ, CMD_BURST_STOP, CMD_ACTIVE,
    CMD_REFRESH, CMD_LOAD_MODE, CMD_WRITE, CMD_PRECHARGE, CMD_READ};
  int pre [8] = '{0, 0, 1, 1, 1, 2, 1, 3};

  always #4 i_core_clk = ~i_core_clk;

  lbcl_cmd_if cmd_bus();
  lbcl_controller i_lbcl_controller(.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_req_valid(req_valid), .i_req_cmd(req_cmd),
    .i_req_bank(req_bank), .i_req_a10(req_a10), .i_cke(cke),
    .o_req_ready(req_ready), .o_illegal_seen(illegal_seen), .cmd(cmd_bus));
  lbcl_device i_lbcl_device(.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .cmd(cmd_bus), .o_all_idle(all_idle), .o_bank_state(bank_state),
    .o_dev_state(dev_state), .o_illegal());
  lbcl_cmd_props i_props(.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .cke(cmd_bus.cke), .cs_n(cmd_bus.cs_n), .ras_n(cmd_bus.ras_n),
    .cas_n(cmd_bus.cas_n), .we_n(cmd_bus.we_n), .bank(cmd_bus.bank),
    .a10(cmd_bus.a10), .illegal(cmd_bus.illegal));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic do_reset;
    i_sys_rst = 1'b1;
    tick(16);
    i_sys_rst = 1'b0;
  endtask

  // Hold the request until ready, then one edge takes it
  task automatic send(input logic [3:0] c, input logic [1:0] b,
                      input logic ap);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_a10 = ap;
    while (req_ready !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    if (n == 50) mismatches++;
    tick(1);
    req_valid = 1'b0;
  endtask

  function automatic logic [15:0] st(input int b);
    return 16'(bank_state[4*b +: 4]);
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 6000);
    mismatches++;
    final_report;
  end

  initial begin
    do_reset;
    check(bank_state, 16'h0);
    check(16'(all_idle), 16'h1);
    send(CMD_ACTIVE, 2'h1, 1'b0);
    tick(1);
    check(st(1), 16'(BANK_ACTIVATING));
    tick(RCD_CYC + 1);
    check(st(1), 16'(BANK_ROW_ACTIVE));
    send(CMD_READ, 2'h1, 1'b0);
    tick(1);
    check(st(1), 16'(BANK_READ));
    send(CMD_BURST_STOP, 2'h0, 1'b0);
    tick(1);
    check(st(1), 16'(BANK_ROW_ACTIVE));
    send(CMD_WRITE, 2'h1, 1'b1);
    tick(1);
    check(st(1), 16'(BANK_WRITE_AP));
    send(CMD_ACTIVE, 2'h2, 1'b0);
    tick(1);
    check(st(2), 16'(BANK_ACTIVATING));
    tick(12);
    check(st(1), 16'(BANK_IDLE));
    send(CMD_READ, 2'h2, 1'b1);
    tick(1);
    check(st(2), 16'(BANK_READ_AP));
    tick(BURST_CYC + RP_CYC + 2);
    check(st(2), 16'(BANK_IDLE));
    send(CMD_ACTIVE, 2'h0, 1'b0);
    tick(RCD_CYC + 2);
    send(CMD_PRECHARGE, 2'h0, 1'b1);
    tick(1);
    check(16'(dev_state), 16'(DEV_PRECHARGE_ALL));
    tick(RP_CYC + 1);
    check(bank_state, 16'h0);
    send(CMD_REFRESH, 2'h0, 1'b0);
    tick(1);
    check(16'(dev_state), 16'(DEV_REFRESHING));
    check(16'(req_ready), 16'h0);
    tick(RFC_CYC + 1);
    check(16'(dev_state), 16'(DEV_NORMAL));
    send(CMD_LOAD_MODE, 2'h0, 1'b0);
    tick(1);
    check(16'(dev_state), 16'(DEV_MODE_ACCESS));
    tick(MRD_CYC + 1);
    check(16'(all_idle), 16'h1);
    check(16'(illegal_seen), 16'h0);
    cke = 1'b0;
    send(CMD_READ, 2'h3, 1'b0);
    tick(2);
    cke = 1'b1;
    tick(2);
    check(16'(illegal_seen), 16'h0);
    // Overlapping banks, write autoprecharge spacing met exactly
    send(CMD_ACTIVE, 2'h0, 1'b0);
    tick(1);
    check(st(0), 16'(BANK_ACTIVATING));
    send(CMD_ACTIVE, 2'h1, 1'b0);
    tick(RCD_CYC + 2);
    check(st(1), 16'(BANK_ROW_ACTIVE));
    send(CMD_WRITE, 2'h0, 1'b1);
    tick(1);
    send(CMD_WRITE, 2'h1, 1'b0);
    tick(1);
    send(CMD_READ, 2'h1, 1'b0);
    tick(3);
    check(16'(illegal_seen), 16'h0);
    send(CMD_PRECHARGE, 2'h1, 1'b0);
    tick(1);
    check(st(1), 16'(BANK_PRECHARGING));
    // Each bad command after a fresh reset, from idle or prepared banks
    for (int i = 0; i < 8; i++) begin
      do_reset;
      if (pre[i] != 0) begin
        send(CMD_ACTIVE, 2'h0, 1'b0);
        tick(1);
      end
      if (pre[i] == 2) begin
        tick(RCD_CYC + 1);
        send(CMD_READ, 2'h0, 1'b0);
        tick(1);
      end
      if (pre[i] == 3) begin
        send(CMD_ACTIVE, 2'h1, 1'b0);
        tick(RCD_CYC + 2);
        send(CMD_WRITE, 2'h0, 1'b1);
        tick(1);
      end
      send(bad_cmd[i], 2'(pre[i] == 3), bad_cmd[i] == CMD_PRECHARGE);
      tick(3);
      check(16'(illegal_seen), 16'h1);
    end
    final_report;
  end
endmodule // tb
